// [common/oag_pkg.sv]
package oag_pkg;

  // ----------------------------------------------------------------
  // widths and field layout
  // ----------------------------------------------------------------
  localparam int RF_AW  = 12;
  localparam int PM_AW  = 16;
  localparam logic [3:0] ESC_NIB = 4'he;

  // ----------------------------------------------------------------
  // operand modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MD_WREG      = 4'h0,
    MD_WPAIR     = 4'h1,
    MD_REG8      = 4'h2,
    MD_REGPAIR8  = 4'h3,
    MD_IND_WREG  = 4'h4,
    MD_IND_WPAIR = 4'h5,
    MD_IND_REG   = 4'h6,
    MD_IND_RPAIR = 4'h7,
    MD_INDEXED   = 4'h8,
    MD_DIRECT    = 4'h9,
    MD_RELATIVE  = 4'ha,
    MD_IMMEDIATE = 4'hb
  } oag_mode_t;

  typedef enum logic [1:0] {
    RK_REG  = 2'h0,
    RK_PROG = 2'h1,
    RK_PC   = 2'h2,
    RK_DATA = 2'h3
  } oag_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RD1  = 2'h1,
    ST_RD2  = 2'h2,
    ST_PM   = 2'h3
  } oag_state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    oag_mode_t         mode;
    logic [7:0]        windowBasePointer;
    logic [7:0]        opA;
    logic [7:0]        opB;
    logic [PM_AW-1:0]  pcOpcode;
    logic [PM_AW-1:0]  pcNext;
    logic              progTarget;
  } oag_req_t;

  typedef struct packed {
    oag_kind_t         kind;
    logic [PM_AW-1:0]  addr;
    logic [7:0]        data;
    logic              bad;
  } oag_res_t;

  typedef struct packed {
    oag_state_t        st;
    oag_req_t          req;
    logic [RF_AW-1:0]  rfAddr;
    logic [PM_AW-1:0]  pmAddr;
    logic [7:0]        hiByte;
    oag_res_t          res;
    logic              resValid;
  } oag_core_t;

  localparam oag_core_t CORE_RST = '0;

endpackage

// [design/oag_reg_map.sv]
`timescale 1ns/10ps
`default_nettype none

module oag_reg_map (
  input  wire logic [7:0]              windowBasePointer,
  input  wire logic [7:0]              regIn,
  output logic [oag_pkg::RF_AW-1:0]    regAddr
);

  // ----------------------------------------------------------------
  // 8-bit register address to register-file address
  // ----------------------------------------------------------------
  always_comb
  begin
    if (regIn[7:4] == oag_pkg::ESC_NIB)
      regAddr = {windowBasePointer[3:0], windowBasePointer[7:4], regIn[3:0]};
    else
      regAddr = {windowBasePointer[3:0], regIn};
  end

endmodule

`default_nettype wire

// [design/oag_addr_gen.sv]
`timescale 1ns/10ps
`default_nettype none

module oag_addr_gen (
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        reqValid,
  input  wire oag_pkg::oag_req_t           req,
  output logic                             reqReady,
  output logic                             rfReq,
  output logic [oag_pkg::RF_AW-1:0]        rfAddr,
  input  wire logic                        rfAck,
  input  wire logic [7:0]                  rfData,
  output logic                             pmReq,
  output logic [oag_pkg::PM_AW-1:0]        pmAddr,
  input  wire logic                        pmAck,
  input  wire logic [7:0]                  pmData,
  output logic                             resValid,
  output oag_pkg::oag_res_t                res
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  oag_pkg::oag_core_t              core_ff;
  oag_pkg::oag_core_t              nxt_core;
  logic [oag_pkg::RF_AW-1:0]       mapNew;
  logic [oag_pkg::RF_AW-1:0]       mapHeld;

  oag_reg_map u_map_new (
    .windowBasePointer (req.windowBasePointer),
    .regIn             (req.opA),
    .regAddr           (mapNew)
  );

  oag_reg_map u_map_held (
    .windowBasePointer (core_ff.req.windowBasePointer),
    .regIn             (core_ff.req.opA),
    .regAddr           (mapHeld)
  );

  function automatic logic [oag_pkg::RF_AW-1:0] wrkAddr(input logic [7:0] ptr, input logic [3:0] n);
    wrkAddr = {ptr[3:0], ptr[7:4], n};
  endfunction

  assign reqReady = (core_ff.st == oag_pkg::ST_IDLE);
  assign rfReq    = (core_ff.st == oag_pkg::ST_RD1) || (core_ff.st == oag_pkg::ST_RD2);
  assign pmReq    = (core_ff.st == oag_pkg::ST_PM);
  assign rfAddr   = core_ff.rfAddr;
  assign pmAddr   = core_ff.pmAddr;
  assign resValid = core_ff.resValid;
  assign res      = core_ff.res;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_core          = core_ff;
    nxt_core.resValid = 1'b0;
    case (core_ff.st)
      oag_pkg::ST_IDLE:
      begin
        if (reqValid)
        begin
          nxt_core.req     = req;
          nxt_core.res     = '0;
          nxt_core.res.bad = 1'b0;
          case (req.mode)
            oag_pkg::MD_WREG:
            begin
              nxt_core.res.kind = oag_pkg::RK_REG;
              nxt_core.res.addr = {4'h0, wrkAddr(req.windowBasePointer, req.opA[3:0])};
              nxt_core.resValid = 1'b1;
            end
            oag_pkg::MD_WPAIR:
            begin
              nxt_core.res.kind = oag_pkg::RK_REG;
              nxt_core.res.addr = {4'h0, wrkAddr(req.windowBasePointer, req.opA[3:0])};
              nxt_core.res.bad  = req.opA[0];
              nxt_core.resValid = 1'b1;
            end
            oag_pkg::MD_REG8, oag_pkg::MD_REGPAIR8:
            begin
              nxt_core.res.kind = oag_pkg::RK_REG;
              nxt_core.res.addr = {4'h0, mapNew};
              nxt_core.resValid = 1'b1;
            end
            oag_pkg::MD_IND_WREG:
            begin
              nxt_core.rfAddr = wrkAddr(req.windowBasePointer, req.opA[3:0]);
              nxt_core.st     = oag_pkg::ST_RD1;
            end
            oag_pkg::MD_IND_WPAIR:
            begin
              // an odd pair is refused without touching the register file
              if (req.opA[0])
              begin
                nxt_core.res.bad  = 1'b1;
                nxt_core.resValid = 1'b1;
              end
              else
              begin
                nxt_core.rfAddr = wrkAddr(req.windowBasePointer, req.opA[3:0]);
                nxt_core.st     = oag_pkg::ST_RD1;
              end
            end
            oag_pkg::MD_IND_REG, oag_pkg::MD_IND_RPAIR:
            begin
              nxt_core.rfAddr = mapNew;
              nxt_core.st     = oag_pkg::ST_RD1;
            end
            oag_pkg::MD_INDEXED:
            begin
              nxt_core.rfAddr = wrkAddr(req.windowBasePointer, req.opB[3:0]);
              nxt_core.st     = oag_pkg::ST_RD1;
            end
            oag_pkg::MD_DIRECT:
            begin
              nxt_core.res.kind = oag_pkg::RK_PC;
              nxt_core.res.addr = {req.opA, req.opB};
              nxt_core.resValid = 1'b1;
            end
            oag_pkg::MD_RELATIVE:
            begin
              nxt_core.res.kind = oag_pkg::RK_PC;
              nxt_core.res.addr = req.pcNext + {{8{req.opB[7]}}, req.opB};
              nxt_core.resValid = 1'b1;
            end
            oag_pkg::MD_IMMEDIATE:
            begin
              nxt_core.pmAddr = req.pcOpcode + 16'h0001;
              nxt_core.st     = oag_pkg::ST_PM;
            end
            default:
            begin
              // unknown mode answers at once, flagged bad
              nxt_core.res.bad  = 1'b1;
              nxt_core.resValid = 1'b1;
            end
          endcase
        end
      end
      oag_pkg::ST_RD1:
      begin
        if (rfAck)
        begin
          case (core_ff.req.mode)
            oag_pkg::MD_IND_WPAIR, oag_pkg::MD_IND_RPAIR:
            begin
              // pairs are stored high byte first
              nxt_core.hiByte = rfData;
              nxt_core.rfAddr = core_ff.rfAddr + 12'h001;
              nxt_core.st     = oag_pkg::ST_RD2;
            end
            oag_pkg::MD_INDEXED:
            begin
              nxt_core.res.kind = oag_pkg::RK_REG;
              nxt_core.res.addr = {4'h0, core_ff.req.windowBasePointer[3:0],
                                   8'(core_ff.req.opA + rfData)};
              nxt_core.resValid = 1'b1;
              nxt_core.st       = oag_pkg::ST_IDLE;
            end
            default:
            begin
              nxt_core.res.kind = oag_pkg::RK_REG;
              nxt_core.res.addr = {4'h0, core_ff.req.windowBasePointer[3:0], rfData};
              nxt_core.resValid = 1'b1;
              nxt_core.st       = oag_pkg::ST_IDLE;
            end
          endcase
        end
      end
      oag_pkg::ST_RD2:
      begin
        if (rfAck)
        begin
          nxt_core.resValid = 1'b1;
          nxt_core.st       = oag_pkg::ST_IDLE;
          if ((core_ff.req.mode == oag_pkg::MD_IND_WPAIR) && !core_ff.req.progTarget)
          begin
            nxt_core.res.kind = oag_pkg::RK_REG;
            nxt_core.res.addr = {4'h0, core_ff.hiByte[3:0], rfData};
          end
          else
          begin
            nxt_core.res.kind = oag_pkg::RK_PROG;
            nxt_core.res.addr = {core_ff.hiByte, rfData};
          end
        end
      end
      oag_pkg::ST_PM:
      begin
        if (pmAck)
        begin
          nxt_core.res.kind = oag_pkg::RK_DATA;
          nxt_core.res.data = pmData;
          nxt_core.resValid = 1'b1;
          nxt_core.st       = oag_pkg::ST_IDLE;
        end
      end
      default:
      begin
        nxt_core.st = oag_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      core_ff <= oag_pkg::CORE_RST;
    else
      core_ff <= nxt_core;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  logic takeNew;
  assign takeNew = reqValid && reqReady;

  chk_wreg_map: assert property (
    takeNew && req.mode == oag_pkg::MD_WREG |=> resValid && res.kind == oag_pkg::RK_REG
      && res.addr[11:0] == {$past(req.windowBasePointer[3:0]), $past(req.windowBasePointer[7:4]), $past(req.opA[3:0])})
    else $error("working register address wrong");

  chk_pair_odd: assert property (
    takeNew && (req.mode == oag_pkg::MD_WPAIR || req.mode == oag_pkg::MD_IND_WPAIR) && req.opA[0]
      |=> resValid && res.bad && !rfReq)
    else $error("odd working pair not refused");

  chk_reg8_norm: assert property (
    takeNew && req.mode == oag_pkg::MD_REG8 && req.opA[7:4] != 4'he
      |=> res.addr[11:0] == {$past(req.windowBasePointer[3:0]), $past(req.opA)})
    else $error("normal register address wrong");

  chk_rpair_esc: assert property (
    takeNew && req.mode == oag_pkg::MD_REGPAIR8 && req.opA[7:4] == 4'he
      |=> res.addr[11:0] == {$past(req.windowBasePointer[3:0]), $past(req.windowBasePointer[7:4]), $past(req.opA[3:0])})
    else $error("escaped pair address wrong");

  chk_ind_byte: assert property (
    rfReq && rfAck && core_ff.st == oag_pkg::ST_RD1
      && (core_ff.req.mode == oag_pkg::MD_IND_WREG || core_ff.req.mode == oag_pkg::MD_IND_REG)
      |=> resValid && res.addr[11:0] == {core_ff.req.windowBasePointer[3:0], $past(rfData)})
    else $error("indirect byte address wrong");

  chk_ind_reg_src: assert property (
    takeNew && req.mode == oag_pkg::MD_IND_REG |=> rfReq && rfAddr == $past(mapNew))
    else $error("indirect register source wrong");

  chk_pair_prog: assert property (
    core_ff.st == oag_pkg::ST_RD2 && rfAck && core_ff.req.mode == oag_pkg::MD_IND_RPAIR
      |=> resValid && res.kind == oag_pkg::RK_PROG && res.addr == {$past(core_ff.hiByte), $past(rfData)})
    else $error("register pair target not program");

  // the held source address must not drift while the first read waits
  chk_rpair_src: assert property (
    rfReq && core_ff.st == oag_pkg::ST_RD1
      && (core_ff.req.mode == oag_pkg::MD_IND_REG || core_ff.req.mode == oag_pkg::MD_IND_RPAIR)
      |-> rfAddr == mapHeld)
    else $error("held register source address wrong");

  chk_wpair_reg: assert property (
    core_ff.st == oag_pkg::ST_RD2 && rfAck && core_ff.req.mode == oag_pkg::MD_IND_WPAIR
      && !core_ff.req.progTarget |=> res.kind == oag_pkg::RK_REG && res.addr[7:0] == $past(rfData))
    else $error("working pair register target wrong");

  chk_idx_sum: assert property (
    core_ff.st == oag_pkg::ST_RD1 && rfAck && core_ff.req.mode == oag_pkg::MD_INDEXED
      |=> res.addr[7:0] == 8'($past(core_ff.req.opA) + $past(rfData)))
    else $error("indexed sum wrong");

  chk_direct_pc: assert property (
    takeNew && req.mode == oag_pkg::MD_DIRECT |=> res.kind == oag_pkg::RK_PC
      && res.addr == {$past(req.opA), $past(req.opB)})
    else $error("direct target wrong");

  chk_rel_pc: assert property (
    takeNew && req.mode == oag_pkg::MD_RELATIVE
      |=> res.addr == 16'($past(req.pcNext) + {{8{$past(req.opB[7])}}, $past(req.opB)}))
    else $error("relative target wrong");

  chk_imm_fetch: assert property (
    takeNew && req.mode == oag_pkg::MD_IMMEDIATE |=> pmReq && pmAddr == 16'($past(req.pcOpcode) + 16'h0001))
    else $error("immediate fetch address wrong");

  cov_indexed: cover property (takeNew && req.mode == oag_pkg::MD_INDEXED ##[1:8] resValid);
  cov_pair_prog: cover property (core_ff.st == oag_pkg::ST_RD2 ##1 resValid && res.kind == oag_pkg::RK_PROG);
  cov_escaped: cover property (takeNew && req.mode == oag_pkg::MD_REG8 && req.opA[7:4] == 4'he);

endmodule

`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_top;

  typedef struct packed {
    oag_pkg::oag_mode_t mode;
    oag_pkg::oag_res_t  res;
    logic [3:0]         msk;
  } oag_exp_t;

  logic                       clk_sys;
  logic                       sys_rst;
  logic                       reqValid;
  logic                       reqReady;
  logic                       rfReq;
  logic                       rfAck;
  logic                       pmReq;
  logic                       pmAck;
  logic                       resValid;
  logic [7:0]                 rfData;
  logic [7:0]                 pmData;
  logic [oag_pkg::RF_AW-1:0]  rfAddr;
  logic [oag_pkg::PM_AW-1:0]  pmAddr;
  oag_pkg::oag_req_t          req;
  oag_pkg::oag_req_t          r;
  oag_pkg::oag_res_t          res;
  oag_exp_t                   cur;
  oag_exp_t                   expQ[$];
  oag_pkg::oag_req_t          dir[$];
  logic [7:0]                 seed = 8'h46;
  logic [7:0]                 rs = 8'h46;
  logic [7:0]                 t;
  int                         err_total = 0;
  int                         checks_done = 0;
  int                         n;

  oag_addr_gen u_dut (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .reqValid (reqValid),
    .req      (req),
    .reqReady (reqReady),
    .rfReq    (rfReq),
    .rfAddr   (rfAddr),
    .rfAck    (rfAck),
    .rfData   (rfData),
    .pmReq    (pmReq),
    .pmAddr   (pmAddr),
    .pmAck    (pmAck),
    .pmData   (pmData),
    .resValid (resValid),
    .res      (res)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] nx();
    seed = lfsr(seed);
    return seed;
  endfunction

  // memory contents are a function of the address so a wrong address shows up
  function automatic logic [7:0] rfByte(logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h3c;
  endfunction

  function automatic logic [7:0] pmByte(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction

  function automatic logic [11:0] wreg(logic [7:0] p, logic [7:0] x);
    return {p[3:0], p[7:4], x[3:0]};
  endfunction

  function automatic logic [11:0] map8(logic [7:0] p, logic [7:0] x);
    return (x[7:4] == 4'he) ? {p[3:0], p[7:4], x[3:0]} : {p[3:0], x};
  endfunction

  function automatic oag_pkg::oag_req_t mk(oag_pkg::oag_mode_t m, logic [7:0] p, logic [7:0] a, logic [7:0] b,
                                           logic [15:0] pc, logic [15:0] pn, logic pt);
    return '{m, p, a, b, pc, pn, pt};
  endfunction

  // msk bits: kind, addr, data, bad
  function automatic oag_exp_t predict(oag_pkg::oag_req_t q);
    oag_exp_t    e;
    logic [11:0] a;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [7:0]  p;
    p = q.windowBasePointer;
    e = '{q.mode, '0, 4'b1101};
    case (q.mode)
      oag_pkg::MD_WREG, oag_pkg::MD_WPAIR:
      begin
        e.res.addr = {4'h0, wreg(p, q.opA)};
        e.res.bad  = (q.mode == oag_pkg::MD_WPAIR) & q.opA[0];
      end
      oag_pkg::MD_REG8, oag_pkg::MD_REGPAIR8: e.res.addr = {4'h0, map8(p, q.opA)};
      oag_pkg::MD_IND_WREG: e.res.addr = {4'h0, p[3:0], rfByte(wreg(p, q.opA))};
      oag_pkg::MD_IND_REG: e.res.addr = {4'h0, p[3:0], rfByte(map8(p, q.opA))};
      oag_pkg::MD_INDEXED: e.res.addr = {4'h0, p[3:0], q.opA + rfByte(wreg(p, q.opB))};
      oag_pkg::MD_IND_WPAIR, oag_pkg::MD_IND_RPAIR:
      begin
        a  = (q.mode == oag_pkg::MD_IND_WPAIR) ? wreg(p, q.opA) : map8(p, q.opA);
        hi = rfByte(a);
        lo = rfByte(a + 12'h1);
        e.res.kind = oag_pkg::RK_PROG;
        e.res.addr = {hi, lo};
        if (q.mode == oag_pkg::MD_IND_WPAIR && !q.progTarget)
        begin
          e.res.kind = oag_pkg::RK_REG;
          e.res.addr = {4'h0, hi[3:0], lo};
        end
        if (q.mode == oag_pkg::MD_IND_WPAIR && q.opA[0])
          e = '{q.mode, '{oag_pkg::RK_REG, 16'h0, 8'h0, 1'b1}, 4'b0001};
      end
      oag_pkg::MD_DIRECT: e.res = '{oag_pkg::RK_PC, {q.opA, q.opB}, 8'h0, 1'b0};
      oag_pkg::MD_RELATIVE: e.res = '{oag_pkg::RK_PC, q.pcNext + {{8{q.opB[7]}}, q.opB}, 8'h0, 1'b0};
      oag_pkg::MD_IMMEDIATE: e = '{q.mode, '{oag_pkg::RK_DATA, 16'h0, pmByte(q.pcOpcode + 16'h1), 1'b0}, 4'b1011};
      default: e = '{q.mode, '{oag_pkg::RK_REG, 16'h0, 8'h0, 1'b1}, 4'b0001};
    endcase
    return e;
  endfunction

  task automatic cmpVal(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks_done++;
    if (ex !== got)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic cmpRes(input oag_exp_t e, input oag_pkg::oag_res_t g);
    if (e.msk[3]) cmpVal("kind", {14'h0, e.res.kind}, {14'h0, g.kind});
    if (e.msk[2]) cmpVal("addr", e.res.addr, g.addr);
    if (e.msk[1]) cmpVal("data", {8'h0, e.res.data}, {8'h0, g.data});
    if (e.msk[0]) cmpVal("bad", {15'h0, e.res.bad}, {15'h0, g.bad});
  endtask

  // request is held until a rising edge that sees reqReady high
  task automatic issue(input oag_pkg::oag_req_t q);
    int k;
    expQ.push_back(predict(q));
    reqValid <= 1'b1;
    req      <= q;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (reqReady !== 1'b1 && k < 50);
    if (k >= 50) cmpVal("reqReady", 16'h1, 16'h0);
  endtask

  task automatic end_of_test();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, responders, monitor, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // answers come promptly or late at random; data line inverts when idle
  always @(posedge clk_sys)
  begin
    rs = lfsr(rs);
    rfAck  <= rfReq && !rfAck && rs[0];
    rfData <= (rfReq && !rfAck) ? rfByte(rfAddr) : ~rfData;
    pmAck  <= pmReq && !pmAck && rs[1];
    pmData <= (pmReq && !pmAck) ? pmByte(pmAddr) : ~pmData;
  end

  always @(posedge clk_sys)
  begin
    if (!sys_rst && resValid === 1'b1)
    begin
      if (expQ.size() == 0)
        cmpVal("resValid", 16'h0, 16'h1);
      else
      begin
        cur = expQ.pop_front();
        case (cur.mode)
          oag_pkg::MD_WREG, oag_pkg::MD_WPAIR: cmpRes(cur, res);
          oag_pkg::MD_REG8, oag_pkg::MD_REGPAIR8: cmpRes(cur, res);
          oag_pkg::MD_IND_WREG, oag_pkg::MD_IND_WPAIR: cmpRes(cur, res);
          oag_pkg::MD_IND_REG, oag_pkg::MD_IND_RPAIR: cmpRes(cur, res);
          oag_pkg::MD_INDEXED: cmpRes(cur, res);
          oag_pkg::MD_DIRECT, oag_pkg::MD_RELATIVE: cmpRes(cur, res);
          default: cmpRes(cur, res);
        endcase
      end
    end
  end

  initial
  begin
    #200000;
    err_total++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst  = 1'b1;
    reqValid = 1'b0;
    req      = '0;
    rfAck    = 1'b0;
    rfData   = 8'h0;
    pmAck    = 1'b0;
    pmData   = 8'h0;
    repeat (2) @(posedge clk_sys);
    cmpVal("reqReady", 16'h1, {15'h0, reqReady});
    cmpVal("resValid", 16'h0, {15'h0, resValid});
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    // escape range edges, odd pairs, 12-bit and 16-bit wrap, offset limits
    dir.push_back(mk(oag_pkg::MD_WREG, 8'h3c, 8'h0f, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_WPAIR, 8'h3c, 8'h0e, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_WPAIR, 8'h3c, 8'h03, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_REG8, 8'ha5, 8'hdf, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_REG8, 8'ha5, 8'he0, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_REG8, 8'ha5, 8'hef, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_REG8, 8'ha5, 8'hf0, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_REGPAIR8, 8'h71, 8'he6, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_IND_WPAIR, 8'h71, 8'h0e, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_IND_WPAIR, 8'h71, 8'h04, 8'h00, 16'h0, 16'h0, 1'b1));
    dir.push_back(mk(oag_pkg::MD_IND_WPAIR, 8'h71, 8'h05, 8'h00, 16'h0, 16'h0, 1'b1));
    dir.push_back(mk(oag_pkg::MD_IND_RPAIR, 8'h2f, 8'hff, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_IND_REG, 8'h2f, 8'he2, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_DIRECT, 8'h00, 8'hff, 8'hff, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_DIRECT, 8'h00, 8'h00, 8'h00, 16'h0, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::MD_RELATIVE, 8'h00, 8'h00, 8'h7f, 16'h0, 16'hfffe, 1'b0));
    dir.push_back(mk(oag_pkg::MD_RELATIVE, 8'h00, 8'h00, 8'h80, 16'h0, 16'h0005, 1'b0));
    dir.push_back(mk(oag_pkg::MD_IMMEDIATE, 8'h00, 8'h00, 8'h00, 16'h12fe, 16'h0, 1'b0));
    dir.push_back(mk(oag_pkg::oag_mode_t'(4'hc), 8'h00, 8'h00, 8'h00, 16'h0, 16'h0, 1'b0));
    foreach (dir[i]) issue(dir[i]);
    for (int i = 0; i < 300; i++)
    begin
      t = nx();
      r = mk(oag_pkg::oag_mode_t'(t[3:0]), nx(), nx(), nx(), {nx(), nx()}, {nx(), nx()}, t[4]);
      issue(r);
    end
    reqValid <= 1'b0;
    for (n = 0; n < 100 && expQ.size() != 0; n++) @(posedge clk_sys);
    cmpVal("pending", 16'h0, 16'(expQ.size()));
    end_of_test();
  end

endmodule

`default_nettype wire
